// >>> dv/tb_system_clock_source_select.sv
/*
 Self-checking bench for the system clock source select block: register
 bus traffic, divider rates, source switching, crystal settling and the
 missing-clock detector.
 Assumes scs_pkg is compiled first; the bench drives every input itself.
*/
module tb_system_clock_source_select;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // signals and design
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic [7:0] sfrWdata = 8'h00;
    logic [7:0] sfrRdata;
    logic extOscPinA = 1'b0;
    logic coreClockTick;
    logic extClockTick;
    logic intOscEnable;
    logic [6:0] oscPeriodTrim;
    logic mcdResetReq;
    logic pinRun = 1'b0;
    logic [1:0] halfCnt = 2'h0;
    int bad_count = 0;
    int n_compared = 0;

    scs_clock_select #(.MCD_TIMEOUT_CYCLES(20), .SETTLE_EDGES(4)) u_scs_clock_select (
        .clk(clk),
        .reset(reset),
        .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite),
        .sfrRead(sfrRead),
        .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata),
        .extOscPinA(extOscPinA),
        .coreClockTick(coreClockTick),
        .extClockTick(extClockTick),
        .intOscEnable(intOscEnable),
        .oscPeriodTrim(oscPeriodTrim),
        .mcdResetReq(mcdResetReq)
    );

    always #20 clk = ~clk;

    // external source: pin toggles every third clock, six clocks a period
    always @(posedge clk)
    begin
        if (pinRun)
        begin
            halfCnt <= (halfCnt == 2'h2) ? 2'h0 : halfCnt + 2'h1;
            if (halfCnt == 2'h2)
                extOscPinA <= ~extOscPinA;
        end
    end

    // ========================================
    // helpers
    function automatic int divGap(input logic [1:0] code);
        divGap = 8 >> code;
    endfunction

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_gap(input int got, input int exp);
        n_compared++;
        if (got != exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t gap got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge clk);
        sfrWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge clk);
        sfrRead <= 1'b0;
        #1;
        check_val(sfrRdata, exp);
    endtask

    // gap in clocks between two pulses of the chosen tick, 0 if fewer than three seen
    task automatic gap_of(input bit useExt, output int gap);
        int n;
        int seen;
        seen = 0;
        gap = 0;
        n = 0;
        while (seen < 3 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
            if (seen > 1)
                gap++;
            if ((useExt ? extClockTick : coreClockTick) === 1'b1)
                seen++;
        end
        if (seen < 3)
            gap = 0;
    endtask

    // ========================================
    // tests
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end

    initial
    begin
        int g;
        int k;
        logic [1:0] code;
        logic [6:0] trim;
        logic [7:0] hole;
        void'($urandom(32'h14F0));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        check_val({1'b0, oscPeriodTrim}, 8'h40);
        check_val({7'h0, intOscEnable}, 8'h01);
        rd(scs_pkg::ADDR_INT_OSC_CTRL, 8'hC0);
        rd(scs_pkg::ADDR_OSC_PERIOD_TRIM, 8'h40);
        gap_of(1'b0, g);
        check_gap(g, divGap(2'h0));
        // every divider code, starting at a random one
        k = $urandom % 4;
        for (int i = 0; i < 4; i++)
        begin
            code = 2'(k + i);
            wr(scs_pkg::ADDR_INT_OSC_CTRL, {6'h20, code});
            rd(scs_pkg::ADDR_INT_OSC_CTRL, {6'h30, code});
            gap_of(1'b0, g);
            check_gap(g, divGap(code));
        end
        // oscillator off: ready drops and the core clock stops
        wr(scs_pkg::ADDR_INT_OSC_CTRL, 8'h03);
        rd(scs_pkg::ADDR_INT_OSC_CTRL, 8'h03);
        gap_of(1'b0, g);
        check_gap(g, 0);
        // enable and undivided in one write
        wr(scs_pkg::ADDR_INT_OSC_CTRL, 8'h83);
        rd(scs_pkg::ADDR_INT_OSC_CTRL, 8'hC3);
        trim = 7'($urandom % 96);
        wr(scs_pkg::ADDR_OSC_PERIOD_TRIM, {1'b0, trim});
        rd(scs_pkg::ADDR_OSC_PERIOD_TRIM, {1'b0, trim});
        check_val({1'b0, oscPeriodTrim}, {1'b0, trim});
        hole = 8'h90 + 8'($urandom % 16);
        wr(hole, 8'hFF);
        rd(hole, 8'h00);
        // external cmos clock feeds peripherals while internal runs the core
        wr(scs_pkg::ADDR_EXT_OSC_CTRL, 8'h20);
        pinRun <= 1'b1;
        gap_of(1'b1, g);
        check_gap(g, 6);
        gap_of(1'b0, g);
        check_gap(g, 1);
        wr(scs_pkg::ADDR_CLK_SELECT, 8'h01);
        rd(scs_pkg::ADDR_CLK_SELECT, 8'h01);
        gap_of(1'b0, g);
        check_gap(g, 6);
        // rc mode: usable at once, core sees every second edge
        wr(scs_pkg::ADDR_EXT_OSC_CTRL, 8'h45);
        rd(scs_pkg::ADDR_EXT_OSC_CTRL, 8'h45);
        gap_of(1'b0, g);
        check_gap(g, 12);
        // back to internal /8 on the fly, detector must stay quiet
        wr(scs_pkg::ADDR_CLK_SELECT, 8'h00);
        wr(scs_pkg::ADDR_INT_OSC_CTRL, 8'h80);
        wr(scs_pkg::ADDR_MCD_CTRL, 8'h01);
        k = 0;
        repeat (60)
        begin
            @(posedge clk);
            #1;
            if (mcdResetReq === 1'b1)
                k++;
        end
        check_gap(k, 0);
        // crystal mode: settled flag only after the oscillator has run
        pinRun <= 1'b0;
        wr(scs_pkg::ADDR_EXT_OSC_CTRL, 8'h60);
        rd(scs_pkg::ADDR_EXT_OSC_CTRL, 8'h60);
        pinRun <= 1'b1;
        repeat (40) @(posedge clk);
        rd(scs_pkg::ADDR_EXT_OSC_CTRL, 8'hE0);
        // external selected, then the pin stops dead
        wr(scs_pkg::ADDR_CLK_SELECT, 8'h01);
        pinRun <= 1'b0;
        k = 0;
        // one timeout only: the detector re-arms and pulses again 20 later
        repeat (30)
        begin
            @(posedge clk);
            #1;
            if (mcdResetReq === 1'b1)
                k++;
        end
        check_gap(k, 1);
        rd(scs_pkg::ADDR_MCD_CTRL, 8'h03);
        // a second reset returns to the internal source whatever was chosen
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(scs_pkg::ADDR_CLK_SELECT, 8'h00);
        rd(scs_pkg::ADDR_INT_OSC_CTRL, 8'hC0);
        gap_of(1'b0, g);
        check_gap(g, 8);
        close_out();
    end
endmodule

// >>> rtl/scs_clock_select.sv
/*
 System clock source select: internal oscillator control with post-divider,
 trim register, external oscillator mode and settle flag, clock source
 switch and missing-clock detector.  Clocks are modelled as one-cycle
 ticks on the 25 MHz block clock; the external pin is sampled synchronously.
*/
// Functional notes
// (R01) reset always returns to internal oscillator
// (R02) trim register, factory value after reset
// (R03) software keeps trim below 25 MHz
// (R04) internal clock divided by 1,2,4,8
// (R05) divider code 11 passes clock undivided
// (R06) codes 00,01,10 divide by 8,4,2
// (R07) bit7 enables oscillator, bit6 reports ready
// (R08) select bit 1 external, 0 internal
// (R09) external clock always feeds peripheral tick
// (R10) run-time switching; software switches only settled sources
// (R11) enable and divider in one write work
// (R12) crystal settled flag set after stabilising
// (R13) software waits 1 ms before flag check
// (R14) software sets external type and frequency first
// (R15) RC and C modes usable at once
// (R16) missing clock timeout starts a reset
module scs_clock_select #(
    parameter int MCD_TIMEOUT_CYCLES = scs_pkg::MCD_CYCLES,
    parameter int SETTLE_EDGES = scs_pkg::SETTLE_EDGES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [scs_pkg::ADDR_W-1:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [scs_pkg::DATA_W-1:0] sfrWdata,
    output logic [scs_pkg::DATA_W-1:0] sfrRdata,
    input wire logic extOscPinA,
    output logic coreClockTick,
    output logic extClockTick,
    output logic intOscEnable,
    output logic [scs_pkg::TRIM_W-1:0] oscPeriodTrim,
    output logic mcdResetReq
);
    scs_pkg::scs_state_type st_r;
    scs_pkg::scs_state_type st_nxt;
    logic intTick;
    logic extRise;
    logic extHalved;
    logic extReady;
    logic crystalMode;

    localparam logic [scs_pkg::MCD_CNT_W-1:0] MCD_LAST =
        scs_pkg::MCD_CNT_W'(MCD_TIMEOUT_CYCLES - 1);
    localparam logic [scs_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
        scs_pkg::SETTLE_CNT_W'(SETTLE_EDGES - 1);

    // ========================================
    // internal oscillator post-divider
    scs_int_divider u_div (
        .clk(clk),
        .reset(reset),
        .enable(st_r.intEn),
        .divSel(st_r.intDiv),
        .tick(intTick)
    );

    // ========================================
    // external oscillator decode
    assign crystalMode = (st_r.extMode[2:1] == 2'h3);
    assign extRise = extOscPinA && !st_r.extPrev && (st_r.extMode[2:1] != 2'h0);
    // the /2 modes keep every second rising edge
    assign extHalved = (st_r.extMode == scs_pkg::EXT_CMOS_DIV2)
        || (st_r.extMode[2:1] == 2'h2) || (st_r.extMode == 3'h7);
    // RC, C and CMOS count as ready once enabled; crystal waits for settle
    assign extReady = crystalMode ? st_r.xtalOk : (st_r.extMode[2:1] != 2'h0); // R15

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.extPrev = extOscPinA;
        st_nxt.mcdReset = 1'b0;
        st_nxt.intRdy = st_r.intEn; // R07

        // ========================================
        // external edges, halving and settle count
        st_nxt.extTick = extRise; // R09
        if (extRise)
        begin
            st_nxt.extHalf = !st_r.extHalf;
        end
        if (!crystalMode)
        begin
            st_nxt.settleCnt = '0;
            st_nxt.xtalOk = 1'b0; // R12
        end
        else if (extRise && !st_r.xtalOk)
        begin
            if (st_r.settleCnt == SETTLE_LAST)
            begin
                st_nxt.xtalOk = 1'b1; // R12
            end
            else
            begin
                st_nxt.settleCnt = st_r.settleCnt + 1'b1;
            end
        end

        // ========================================
        // system clock source
        if (st_r.clock_select_register)
        begin
            // switch is immediate; software only picks a settled source
            st_nxt.sysTick = extRise && extReady && (!extHalved || st_r.extHalf); // R08 R10
        end
        else
        begin
            st_nxt.sysTick = intTick; // R04 R08
        end

        // ========================================
        // missing clock detector
        if (!st_r.mcdEn || st_r.sysTick)
        begin
            st_nxt.mcdCnt = '0;
        end
        else if (st_r.mcdCnt == MCD_LAST)
        begin
            st_nxt.mcdCnt = '0;
            st_nxt.mcdReset = 1'b1; // R16
            st_nxt.mcdFlag = 1'b1;
        end
        else
        begin
            st_nxt.mcdCnt = st_r.mcdCnt + 1'b1;
        end

        // ========================================
        // register writes
        if (sfrWrite)
        begin
            case (sfrAddr)
                scs_pkg::ADDR_INT_OSC_CTRL:
                begin
                    // enable and divider in one write: no start-up wait needed
                    st_nxt.intEn = sfrWdata[scs_pkg::INT_EN_BIT]; // R07 R11
                    st_nxt.intDiv = sfrWdata[1:0]; // R04 R05 R06
                end
                scs_pkg::ADDR_OSC_PERIOD_TRIM:
                begin
                    st_nxt.trim = sfrWdata[scs_pkg::TRIM_W-1:0]; // R02
                end
                scs_pkg::ADDR_EXT_OSC_CTRL:
                begin
                    st_nxt.extMode = sfrWdata[scs_pkg::EXT_MODE_LSB+:3];
                    st_nxt.extFcn = sfrWdata[2:0];
                end
                scs_pkg::ADDR_CLK_SELECT:
                begin
                    st_nxt.clock_select_register = sfrWdata[0]; // R08 R10
                end
                scs_pkg::ADDR_MCD_CTRL:
                begin
                    st_nxt.mcdEn = sfrWdata[scs_pkg::MCD_EN_BIT];
                    // write-one-to-clear; a timeout this cycle wins
                    if (sfrWdata[scs_pkg::MCD_FLAG_BIT] && !st_nxt.mcdReset)
                    begin
                        st_nxt.mcdFlag = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // ========================================
        // register reads, one cycle latency; unmapped reads zero
        st_nxt.rdata = '0;
        if (sfrRead)
        begin
            case (sfrAddr)
                scs_pkg::ADDR_INT_OSC_CTRL:
                    st_nxt.rdata = {st_r.intEn, st_r.intRdy, 4'h0, st_r.intDiv}; // R07
                scs_pkg::ADDR_OSC_PERIOD_TRIM:
                    st_nxt.rdata = {1'b0, st_r.trim};
                scs_pkg::ADDR_EXT_OSC_CTRL:
                    st_nxt.rdata = {st_r.xtalOk, st_r.extMode, 1'b0, st_r.extFcn}; // R12
                scs_pkg::ADDR_CLK_SELECT:
                    st_nxt.rdata = {7'h00, st_r.clock_select_register};
                scs_pkg::ADDR_MCD_CTRL:
                    st_nxt.rdata = {6'h00, st_r.mcdFlag, st_r.mcdEn};
                default:
                    st_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.intEn <= scs_pkg::INT_OSC_CTRL_RESET[scs_pkg::INT_EN_BIT];
            st_r.intRdy <= scs_pkg::INT_OSC_CTRL_RESET[scs_pkg::INT_RDY_BIT];
            st_r.intDiv <= scs_pkg::INT_OSC_CTRL_RESET[1:0];
            st_r.trim <= scs_pkg::TRIM_FACTORY; // R02
            st_r.clock_select_register <= 1'b0; // R01
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign coreClockTick = st_r.sysTick;
    assign extClockTick = st_r.extTick;
    assign intOscEnable = st_r.intEn;
    assign oscPeriodTrim = st_r.trim;
    assign mcdResetReq = st_r.mcdReset;
    assign sfrRdata = st_r.rdata;

    // ========================================
    // checks
    resetInternal_a: assert property (@(posedge clk) reset |=> !st_r.clock_select_register && st_r.intEn) // R01
        else $error("reset did not return to internal oscillator");

    divByOne_a: assert property (@(posedge clk) disable iff (reset) // R05
        (st_r.intEn && st_r.intDiv == scs_pkg::DIV_BY1) |=> intTick)
        else $error("divide-by-one code did not tick every cycle");

    divByEight_a: assert property (@(posedge clk) disable iff (reset) // R06
        (intTick && st_r.intEn && st_r.intDiv == scs_pkg::DIV_BY8)
        ##1 (st_r.intEn && st_r.intDiv == scs_pkg::DIV_BY8)[*8] |-> intTick)
        else $error("divide-by-eight spacing wrong");

    divGap_a: assert property (@(posedge clk) disable iff (reset) // R04
        (intTick && st_r.intDiv != scs_pkg::DIV_BY1) |=> !intTick)
        else $error("divided tick came back to back");

    intReady_a: assert property (@(posedge clk) disable iff (reset) // R07
        st_r.intEn |=> st_r.intRdy)
        else $error("ready flag did not follow enable");

    writeOnce_a: assert property (@(posedge clk) disable iff (reset) // R11
        (sfrWrite && sfrAddr == scs_pkg::ADDR_INT_OSC_CTRL)
        |=> st_r.intEn == $past(sfrWdata[7]) && st_r.intDiv == $past(sfrWdata[1:0]))
        else $error("enable and divider write not taken together");

    srcInternal_a: assert property (@(posedge clk) disable iff (reset) // R08
        (!st_r.clock_select_register && intTick) |=> coreClockTick)
        else $error("internal tick lost on core clock");

    srcExternal_a: assert property (@(posedge clk) disable iff (reset) // R08
        (st_r.clock_select_register && !extRise) |=> !coreClockTick)
        else $error("core tick without external edge");

    periphClock_a: assert property (@(posedge clk) disable iff (reset) // R09
        extRise |=> extClockTick)
        else $error("peripheral tick missed external edge");

    xtalFlag_a: assert property (@(posedge clk) disable iff (reset) // R12
        !crystalMode |=> !st_r.xtalOk)
        else $error("settled flag set outside crystal mode");

    missingClock_a: assert property (@(posedge clk) disable iff (reset) // R16
        mcdResetReq |-> $past(st_r.mcdCnt) == MCD_LAST && !$past(st_r.sysTick))
        else $error("missing clock reset at wrong count");
endmodule

// >>> rtl/scs_int_divider.sv
/*
 Post-divider for the internal oscillator: emits a one-cycle tick every
 1, 2, 4 or 8 clocks.  Assumes the oscillator output is the block clock.
*/
module scs_int_divider (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [1:0] divSel,
    output logic tick
);
    scs_pkg::scs_div_state_type state_r;
    scs_pkg::scs_div_state_type state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        if (!enable)
        begin
            state_nxt.cnt = 3'h0;
        end
        else if (state_r.cnt >= scs_pkg::divLimit(divSel))
        begin
            state_nxt.cnt = 3'h0;
            state_nxt.tick = 1'b1;
        end
        else
        begin
            state_nxt.cnt = state_r.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign tick = state_r.tick;
endmodule

// >>> rtl/scs_pkg.sv
/*
 Shared constants and types for the system clock source select block:
 register addresses, field positions, reset values, divider and
 external-mode codes, timing figures and the packed state records.
 Assumes a single 25 MHz clock and a byte-wide special-register bus.
*/
package scs_pkg;

    // ========================================
    // bus and register addresses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_INT_OSC_CTRL = 8'h8A;
    localparam logic [7:0] ADDR_OSC_PERIOD_TRIM = 8'h8B;
    localparam logic [7:0] ADDR_EXT_OSC_CTRL = 8'h8C;
    localparam logic [7:0] ADDR_CLK_SELECT = 8'h8D;
    localparam logic [7:0] ADDR_MCD_CTRL = 8'h8E;

    // ========================================
    // fields and reset values
    localparam int TRIM_W = 7;
    localparam logic [6:0] TRIM_FACTORY = 7'h40; // factory trim, value arbitrary here
    localparam logic [7:0] INT_OSC_CTRL_RESET = 8'hC0;
    localparam int INT_EN_BIT = 7;
    localparam int INT_RDY_BIT = 6;
    localparam int SETTLED_BIT = 7;
    localparam int EXT_MODE_LSB = 4;
    localparam int MCD_EN_BIT = 0;
    localparam int MCD_FLAG_BIT = 1;

    localparam logic [1:0] DIV_BY8 = 2'h0;
    localparam logic [1:0] DIV_BY4 = 2'h1;
    localparam logic [1:0] DIV_BY2 = 2'h2;
    localparam logic [1:0] DIV_BY1 = 2'h3;

    localparam logic [2:0] EXT_CMOS = 3'h2;
    localparam logic [2:0] EXT_CMOS_DIV2 = 3'h3;
    localparam logic [2:0] EXT_CRYSTAL = 3'h6;

    // ========================================
    // timing
    localparam int CLK_KHZ = 25000;
    localparam int MCD_TIMEOUT_US = 220;
    localparam int MCD_CYCLES = MCD_TIMEOUT_US * CLK_KHZ / 1000;
    localparam int SETTLE_EDGES = 16;
    localparam int MCD_CNT_W = 16;
    localparam int SETTLE_CNT_W = 8;

    // ========================================
    // types
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } scs_div_state_type;

    typedef struct packed {
        logic [TRIM_W-1:0] trim;
        logic intEn;
        logic intRdy;
        logic [1:0] intDiv;
        logic clock_select_register;
        logic [2:0] extMode;
        logic [2:0] extFcn;
        logic extPrev;
        logic extHalf;
        logic extTick;
        logic [SETTLE_CNT_W-1:0] settleCnt;
        logic xtalOk;
        logic mcdEn;
        logic mcdFlag;
        logic [MCD_CNT_W-1:0] mcdCnt;
        logic mcdReset;
        logic sysTick;
        logic [DATA_W-1:0] rdata;
    } scs_state_type;

    // terminal count of the internal divider for each field code
    function automatic logic [2:0] divLimit(input logic [1:0] code);
        case (code)
            DIV_BY1: divLimit = 3'h0;
            DIV_BY2: divLimit = 3'h1;
            DIV_BY4: divLimit = 3'h3;
            default: divLimit = 3'h7;
        endcase
    endfunction

endpackage
